// [hw/lss_defines.vh]
// shared constants for the led driver startup sequencer
`ifndef LSS_DEFINES_VH
`define LSS_DEFINES_VH

// ----------------------------------------------------------------
// long-low and detection counts, in switching cycles
// ----------------------------------------------------------------
`define LSS_OFF_CYCLES_STD 16'h8000
`define LSS_OFF_CYCLES_LF 16'h2000
`define LSS_DET_CYCLES_STD 12'he00
`define LSS_DET_CYCLES_LF 12'h340

// ----------------------------------------------------------------
// soft-start timer and clock rate
// ----------------------------------------------------------------
`define LSS_SS_TIME_US 21500
`define LSS_CLK_MHZ 100
`define LSS_SS_CYCLES (`LSS_SS_TIME_US * `LSS_CLK_MHZ)

// ----------------------------------------------------------------
// led pin classification codes
// ----------------------------------------------------------------
`define LSS_PIN_SHORT 2'h0
`define LSS_PIN_UNUSED 2'h1
`define LSS_PIN_INUSE 2'h2

`endif

// [hw/lss_long_low.v]
// counter that flags an input held low past a terminal count
`default_nettype none

module lss_long_low #(
    parameter WIDTH = 16
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire tick_i,
    input wire level_i,
    input wire [WIDTH-1:0] limit_i,
    output reg expired_o
);

    reg [WIDTH-1:0] count;

    // count low switching cycles, restart when input returns high
    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            count <= {WIDTH{1'b0}};
            expired_o <= 1'b0;
        end
        else if (level_i)
        begin
            count <= {WIDTH{1'b0}};
            expired_o <= 1'b0;
        end
        else if (tick_i && !expired_o)
        begin
            if (count >= limit_i)
                expired_o <= 1'b1; // more than limit cycles low
            else
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// [hw/lss_sequencer.v]
// startup and fault-latch sequencer for a four-channel led driver
// ----------------------------------------------------------------
// Overview of operation
// - wake on enable only above input lockout
// - boost and channels enabled together by dimming high
// - power-up fault checks gate switching start
// - enable low over 32k cycles shuts off
// - detection needs gate threshold and dimming high
// - wait 3584 (832) cycles before classifying pins
// - classify pin short, unused or in use
// - unused channels disabled, out of feedback
// - hold soft-start while pin shorted, auto-recover
// - output never above undervoltage withholds soft-start
// - output undervoltage shuts down and latches
// - latch clears on lockout or long enable low
// - latch clears on long dimming low, clock stays
// - soft-start ramps target at fixed slope
// - soft-start ends on regulation, 93%, or timer
// - enable brings supply and clock, then gate pull
// - gate threshold enables current reference, wait dimming
// - enable and dimming may be tied together
// - low-frequency variant uses 8192 shutdown cycles
// ----------------------------------------------------------------
`default_nettype none
`include "lss_defines.vh"

module lss_sequencer #(
    parameter LOW_FREQ = 0,
    parameter SS_CYCLES = `LSS_SS_CYCLES,
    parameter RAMP_WIDTH = 12
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire sw_tick_i,
    input wire enable_i,
    input wire dimming_i,
    input wire input_lockout_ok_i,
    input wire gate_on_threshold_i,
    input wire output_shorted_i,
    input wire frequency_program_fault_i,
    input wire current_reference_fault_i,
    input wire [3:0] led_above_detect_i,
    input wire [3:0] led_short_level_i,
    input wire [3:0] led_unused_level_i,
    input wire output_sense_above_uv_i,
    input wire output_sense_at_93pct_i,
    input wire [3:0] led_in_regulation_i,
    output reg supply_on_o,
    output reg clock_output_en_o,
    output reg gate_pull_o,
    output reg current_reference_en_o,
    output reg boost_en_o,
    output reg [3:0] led_sink_channel_en_o,
    output reg [3:0] led_feedback_en_o,
    output reg [3:0] led_short_fault_o,
    output reg output_undervoltage_fault_o,
    output reg soft_start_active_o,
    output reg startup_done_o,
    output reg [RAMP_WIDTH-1:0] ramp_target_o
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam ST_OFF = 3'h0;
    localparam ST_CHECK = 3'h1;
    localparam ST_GATE = 3'h2;
    localparam ST_WAIT_DIM = 3'h3;
    localparam ST_DETECT = 3'h4;
    localparam ST_UV_CHECK = 3'h5;
    localparam ST_SOFT = 3'h6;
    localparam ST_RUN = 3'h7;

    localparam [15:0] OFF_LIMIT = LOW_FREQ ? `LSS_OFF_CYCLES_LF : `LSS_OFF_CYCLES_STD;
    localparam [11:0] DET_LIMIT = LOW_FREQ ? `LSS_DET_CYCLES_LF : `LSS_DET_CYCLES_STD;
    localparam [31:0] SS_LIMIT = SS_CYCLES;
    localparam [31:0] SS_STEP = SS_CYCLES >> RAMP_WIDTH;

    // ------------------------------------------------------------
    // input synchronisers, three stages, change when 2 and 3 agree
    // ------------------------------------------------------------
    reg [2:0] en_sync;
    reg [2:0] dim_sync;
    reg [2:0] lock_sync;
    reg [2:0] gate_sync;
    reg en_f;
    reg dim_f;
    reg lock_f;
    reg gate_f;

    function filt;
        input [2:0] s;
        input prev;
        begin
            filt = (s[1] == s[2]) ? s[2] : prev;
        end
    endfunction

    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            en_sync <= 3'h0;
            dim_sync <= 3'h0;
            lock_sync <= 3'h0;
            gate_sync <= 3'h0;
            en_f <= 1'b0;
            dim_f <= 1'b0;
            lock_f <= 1'b0;
            gate_f <= 1'b0;
        end
        else
        begin
            en_sync <= {en_sync[1:0], enable_i};
            dim_sync <= {dim_sync[1:0], dimming_i};
            lock_sync <= {lock_sync[1:0], input_lockout_ok_i};
            gate_sync <= {gate_sync[1:0], gate_on_threshold_i};
            en_f <= filt(en_sync, en_f);
            dim_f <= filt(dim_sync, dim_f);
            lock_f <= filt(lock_sync, lock_f);
            gate_f <= filt(gate_sync, gate_f);
        end
    end

    // ------------------------------------------------------------
    // long-low counters on enable and dimming
    // ------------------------------------------------------------
    wire en_long_low;
    wire dim_long_low;

    lss_long_low #(.WIDTH(16)) u_en_low (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .tick_i(sw_tick_i),
        .level_i(en_f),
        .limit_i(OFF_LIMIT),
        .expired_o(en_long_low)
    );

    lss_long_low #(.WIDTH(16)) u_dim_low (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .tick_i(sw_tick_i),
        .level_i(dim_f | ~en_f),
        .limit_i(OFF_LIMIT),
        .expired_o(dim_long_low)
    );

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    reg [2:0] state;
    reg [11:0] det_count;
    reg det_armed;
    reg [31:0] ss_count;
    reg [31:0] step_count;
    reg uv_latch;
    reg [3:0] unused_mask;
    wire pwr_fault;
    wire [3:0] active_mask;
    wire all_reg;

    assign pwr_fault = output_shorted_i | frequency_program_fault_i | current_reference_fault_i;
    assign active_mask = ~unused_mask;
    assign all_reg = &(led_in_regulation_i | unused_mask);

    // latch cleared by lockout, long enable low, or long dimming low
    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            uv_latch <= 1'b0;
        else if (state == ST_UV_CHECK && !output_sense_above_uv_i && det_armed)
            uv_latch <= 1'b1; // set wins over clear
        else if (!lock_f || en_long_low || dim_long_low)
            uv_latch <= 1'b0;
    end

    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= ST_OFF;
            det_count <= 12'h0;
            det_armed <= 1'b0;
            ss_count <= 32'h0;
            step_count <= 32'h0;
            unused_mask <= 4'h0;
            led_short_fault_o <= 4'h0;
            ramp_target_o <= {RAMP_WIDTH{1'b0}};
        end
        else if (!lock_f || en_long_low || uv_latch)
        begin
            state <= ST_OFF;
            det_count <= 12'h0;
            det_armed <= 1'b0;
            ss_count <= 32'h0;
            step_count <= 32'h0;
            unused_mask <= 4'h0;
            led_short_fault_o <= 4'h0;
            ramp_target_o <= {RAMP_WIDTH{1'b0}};
        end
        else
        begin
            case (state)
                ST_OFF:
                    if (en_f)
                        state <= ST_CHECK;
                ST_CHECK:
                    if (!pwr_fault)
                        state <= ST_GATE;
                ST_GATE:
                    if (gate_f)
                        state <= ST_WAIT_DIM;
                ST_WAIT_DIM:
                    if (gate_f && dim_f)
                    begin
                        state <= ST_DETECT;
                        det_count <= 12'h0;
                    end
                ST_DETECT:
                    if (sw_tick_i && (&led_above_detect_i | |led_short_level_i))
                    begin
                        if (det_count >= DET_LIMIT - 12'h1)
                        begin
                            led_short_fault_o <= led_short_level_i;
                            unused_mask <= led_unused_level_i & ~led_short_level_i;
                            if (led_short_level_i == 4'h0)
                            begin
                                state <= ST_UV_CHECK;
                                det_armed <= 1'b0;
                            end
                            else
                                det_count <= 12'h0; // re-examine until short goes
                        end
                        else
                            det_count <= det_count + 12'h1;
                    end
                ST_UV_CHECK:
                    if (output_sense_above_uv_i)
                    begin
                        state <= ST_SOFT;
                        ss_count <= 32'h0;
                        step_count <= 32'h0;
                    end
                    else
                        det_armed <= 1'b1; // one settle cycle, then latch
                ST_SOFT:
                begin
                    ss_count <= ss_count + 32'h1;
                    if (step_count >= SS_STEP)
                    begin
                        step_count <= 32'h0;
                        if (~&ramp_target_o)
                            ramp_target_o <= ramp_target_o + {{(RAMP_WIDTH-1){1'b0}}, 1'b1};
                    end
                    else
                        step_count <= step_count + 32'h1;
                    if (all_reg || output_sense_at_93pct_i || ss_count >= SS_LIMIT - 32'h1)
                        state <= ST_RUN;
                end
                ST_RUN:
                    state <= ST_RUN;
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            supply_on_o <= 1'b0;
            clock_output_en_o <= 1'b0;
            gate_pull_o <= 1'b0;
            current_reference_en_o <= 1'b0;
            boost_en_o <= 1'b0;
            led_sink_channel_en_o <= 4'h0;
            led_feedback_en_o <= 4'h0;
            output_undervoltage_fault_o <= 1'b0;
            soft_start_active_o <= 1'b0;
            startup_done_o <= 1'b0;
        end
        else
        begin
            // supply and clock stay up while latched with enable still high
            supply_on_o <= (state != ST_OFF) || (uv_latch && en_f);
            clock_output_en_o <= (state != ST_OFF) || (uv_latch && en_f);
            gate_pull_o <= (state >= ST_GATE);
            current_reference_en_o <= (state >= ST_WAIT_DIM);
            boost_en_o <= (state >= ST_SOFT) && dim_f;
            led_sink_channel_en_o <= ((state >= ST_SOFT) && dim_f) ? active_mask : 4'h0;
            led_feedback_en_o <= (state >= ST_SOFT) ? active_mask : 4'h0;
            output_undervoltage_fault_o <= uv_latch;
            soft_start_active_o <= (state == ST_SOFT);
            startup_done_o <= (state == ST_RUN);
        end
    end

endmodule

`default_nettype wire

// [dv/lss_seq_assertions.sv]
// concurrent checks on the startup sequencer outputs
`default_nettype none
module lss_seq_chk #(
    parameter SS_CYCLES = 200
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire output_sense_at_93pct_i,
    input wire supply_on_o,
    input wire clock_output_en_o,
    input wire current_reference_en_o,
    input wire boost_en_o,
    input wire [3:0] led_sink_channel_en_o,
    input wire [3:0] led_feedback_en_o,
    input wire [3:0] led_short_fault_o,
    input wire output_undervoltage_fault_o,
    input wire soft_start_active_o,
    input wire startup_done_o,
    input wire [11:0] ramp_target_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    int ss_len;
    // length of the current soft-start phase
    always @(posedge clock_i or negedge arst_n_i)
        if (!arst_n_i)
            ss_len <= 0;
        else
            ss_len <= soft_start_active_o ? ss_len + 1 : 0;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_clk; $rose(clock_output_en_o) |-> supply_on_o && !boost_en_o
        && led_sink_channel_en_o == 4'h0; endproperty
    a_clk: assert property (p_clk) else $error("clock out without supply");
    property p_ref; current_reference_en_o |-> supply_on_o; endproperty
    a_ref: assert property (p_ref) else $error("reference while off");
    property p_boost; boost_en_o |-> soft_start_active_o || startup_done_o; endproperty
    a_boost: assert property (p_boost) else $error("boost too early");
    property p_short; soft_start_active_o |-> led_short_fault_o == 4'h0; endproperty
    a_short: assert property (p_short) else $error("soft-start with short");
    property p_uv; output_undervoltage_fault_o |-> !boost_en_o && !soft_start_active_o;
    endproperty
    a_uv: assert property (p_uv) else $error("running while latched");
    property p_fb; (led_sink_channel_en_o & ~led_feedback_en_o) == 4'h0
        && (!boost_en_o || led_sink_channel_en_o == led_feedback_en_o); endproperty
    a_fb: assert property (p_fb) else $error("feedback from off channel");
    property p_ramp; soft_start_active_o && $past(soft_start_active_o)
        |-> ramp_target_o >= $past(ramp_target_o); endproperty
    a_ramp: assert property (p_ramp) else $error("ramp went down");
    property p_sslen; ss_len <= SS_CYCLES + 2; endproperty
    a_sslen: assert property (p_sslen) else $error("soft-start too long");
    property p_ss93; soft_start_active_o && output_sense_at_93pct_i
        |-> ##[1:3] !soft_start_active_o; endproperty
    a_ss93: assert property (p_ss93) else $error("93 percent ignored");
    property p_done; $rose(startup_done_o) |-> $past(soft_start_active_o); endproperty
    a_done: assert property (p_done) else $error("done without soft-start");
endmodule
`default_nettype wire

// [dv/lss_host_model.sv]
// host model driving the enable and dimming pins
`default_nettype none
module lss_host_model (
    input wire logic clock_i,
    input wire logic en_req_i,
    input wire logic dim_req_i,
    input wire logic tied_i,
    output var logic enable_o,
    output var logic dimming_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {enable_o, dimming_o} = 2'h0;
    // pins change off the sampling edge, long lows held as asked
    always @(negedge clock_i)
    begin
        enable_o <= en_req_i;
        dimming_o <= tied_i ? en_req_i : dim_req_i;
    end
endmodule
`default_nettype wire

// [dv/tb_lss_sequencer.sv]
// self-checking bench for the startup sequencer
`default_nettype none
module tb_lss_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam SS = 200;
    logic clock_i = 1'b0, arst_n_i = 1'b0, en_req = 1'b0, dim_req = 1'b0, tied = 1'b0;
    logic lock_ok = 1'b0, gate_th = 1'b0, out_sh = 1'b0, fp_f = 1'b0, cr_f = 1'b0;
    logic uv_ok = 1'b0, at93 = 1'b0;
    logic [3:0] above = '0, shortl = '0, unusedl = '0, inreg = '0, u;
    logic enable_i, dimming_i, supply_on_o, clock_output_en_o, gate_pull_o, boost_en_o;
    logic current_reference_en_o, output_undervoltage_fault_o;
    logic soft_start_active_o, startup_done_o;
    logic [3:0] led_sink_channel_en_o, led_feedback_en_o, led_short_fault_o;
    logic [11:0] ramp_target_o;
    logic [31:0] seed = 32'h52b2;
    int failures = 0, compares = 0, n, k;
    // clock
    always #5 clock_i = ~clock_i;
    lss_host_model lss_host_model_inst (.clock_i, .en_req_i(en_req), .dim_req_i(dim_req),
        .tied_i(tied), .enable_o(enable_i), .dimming_o(dimming_i));
    lss_sequencer #(.LOW_FREQ(1), .SS_CYCLES(SS)) lss_sequencer_inst (.clock_i, .arst_n_i,
        .sw_tick_i(1'b1), .enable_i, .dimming_i, .input_lockout_ok_i(lock_ok),
        .gate_on_threshold_i(gate_th), .output_shorted_i(out_sh),
        .frequency_program_fault_i(fp_f), .current_reference_fault_i(cr_f),
        .led_above_detect_i(above), .led_short_level_i(shortl),
        .led_unused_level_i(unusedl), .output_sense_above_uv_i(uv_ok),
        .output_sense_at_93pct_i(at93), .led_in_regulation_i(inreg), .supply_on_o,
        .clock_output_en_o, .gate_pull_o, .current_reference_en_o, .boost_en_o,
        .led_sink_channel_en_o, .led_feedback_en_o, .led_short_fault_o,
        .output_undervoltage_fault_o, .soft_start_active_o, .startup_done_o, .ramp_target_o);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // channels left in operation once the unused ones are removed
    function automatic logic [3:0] exp_active(input logic [3:0] unused);
        return ~unused;
    endfunction
    task automatic finish_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int c);
        repeat (c) @(negedge clock_i);
    endtask
    task automatic wait_ss(input logic lvl);
        n = 0;
        while (soft_start_active_o !== lvl)
        begin
            w(1);
            n++;
            if (n > 3000)
            begin
                failures++;
                finish_test;
            end
        end
    endtask
    task automatic boot(input logic [3:0] unused);
        arst_n_i = 1'b0;
        {out_sh, fp_f, cr_f, at93, inreg, shortl, en_req, dim_req, tied} = '0;
        {lock_ok, gate_th, uv_ok, above} = 7'h7f;
        unusedl = unused;
        w(2);
        arst_n_i = 1'b1;
        {en_req, dim_req} = 2'h3;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        boot(4'h0);
        {lock_ok, gate_th} = 2'h0;
        w(50);
        check(supply_on_o, 1'b0);
        check(gate_pull_o, 1'b0);
        lock_ok = 1'b1;
        w(50);
        check({clock_output_en_o, current_reference_en_o, boost_en_o}, 3'h4);
        check(gate_pull_o, 1'b1);
        dim_req = 1'b0;
        gate_th = 1'b1;
        w(1000);
        check({current_reference_en_o, soft_start_active_o}, 2'h2);
        dim_req = 1'b1;
        wait_ss(1'b1);
        $display("test wake ends");
        for (k = 0; k < 3; k++)
        begin
            boot(4'h0);
            {out_sh, fp_f, cr_f} = 3'h1 << k;
            w(1000);
            check(soft_start_active_o, 1'b0);
            {out_sh, fp_f, cr_f} = 3'h0;
            wait_ss(1'b1);
        end
        $display("test power-up faults ends");
        for (k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            u = seed[3:0] & 4'h7;
            boot(u);
            tied = (k == 0);
            wait_ss(1'b1);
            check({n >= 832, n < 880}, 2'h3);
            check({led_sink_channel_en_o, led_feedback_en_o}, {2{exp_active(u)}});
            if (k == 0)
                inreg = exp_active(u);
            if (k == 1)
                at93 = 1'b1;
            wait_ss(1'b0);
            check(k == 2 ? (n > SS - 10 && n < SS + 5) : n < 4, 1'b1);
            check(ramp_target_o != 12'h0, 1'b1);
            check({startup_done_o, boost_en_o}, 2'h3);
            {tied, dim_req} = 2'h0;
            w(20);
            check(boost_en_o, 1'b0);
        end
        {en_req, dim_req} = 2'h0;
        w(5000);
        en_req = 1'b1;
        w(20);
        en_req = 1'b0;
        w(5000);
        check(supply_on_o, 1'b1);
        w(3400);
        check(supply_on_o, 1'b0);
        $display("test detection and soft-start ends");
        boot(4'h0);
        {above, shortl} = 8'he1;
        w(1000);
        check({led_short_fault_o, soft_start_active_o}, 5'h02);
        {above, shortl} = 8'hf0;
        wait_ss(1'b1);
        check(led_short_fault_o, 4'h0);
        $display("test pin short ends");
        for (k = 0; k < 3; k++)
        begin
            boot(4'h0);
            uv_ok = 1'b0;
            w(1000);
            check({output_undervoltage_fault_o, boost_en_o}, 2'h2);
            {lock_ok, en_req, dim_req} = k == 0 ? 3'h3 : (k == 1 ? 3'h5 : 3'h6);
            w(k == 0 ? 20 : 8100);
            check(output_undervoltage_fault_o, k != 0);
            check(clock_output_en_o, k == 2);
            w(300);
            check(output_undervoltage_fault_o, 1'b0);
        end
        $display("test undervoltage latch ends");
        finish_test;
    end
endmodule
bind lss_sequencer lss_seq_chk #(.SS_CYCLES(SS_CYCLES)) lss_seq_chk_inst (.clock_i,
    .arst_n_i, .output_sense_at_93pct_i, .supply_on_o, .clock_output_en_o,
    .current_reference_en_o, .boost_en_o, .led_sink_channel_en_o, .led_feedback_en_o,
    .led_short_fault_o, .output_undervoltage_fault_o, .soft_start_active_o,
    .startup_done_o, .ramp_target_o);
`default_nettype wire
